// [digital_input_counter_modes.sv]
`timescale 1ns/1ps
`default_nettype none
module digital_input_counter_modes #(
    parameter int unsigned DEBOUNCE_CYCLES = din_mode_pkg::DEBOUNCE_CYC,
    parameter int unsigned TICK_CYCLES     = din_mode_pkg::TICK_CYC,
    parameter int unsigned RESET_TICKS     = din_mode_pkg::FREQ_RESET_TK,
    parameter int unsigned DECAY_TICKS     = din_mode_pkg::FREQ_DECAY_TK
) (
    input  wire logic                          sys_clk,
    input  wire logic                          reset,
    input  wire logic                          input_pin_first,
    input  wire logic                          input_pin_second,
    input  wire logic                          input_pin_third,
    input  wire logic                          input_pin_fourth,
    input  wire logic [7:0]                    channel_b_input_config,
    input  wire logic [7:0]                    channel_c_input_config,
    input  wire logic                          firstUsesSecondPin,
    input  wire logic                          analogClaimsSecond,
    input  wire logic                          analogClaimsThird,
    input  wire logic                          powerUp,
    input  wire logic [din_mode_pkg::CNT_W-1:0] savedCountSecond,
    input  wire logic [din_mode_pkg::CNT_W-1:0] savedCountThird,
    input  wire logic                          scaleDone,
    output logic [1:0]                         inputState,
    output logic [din_mode_pkg::CNT_W-1:0]     countSecond,
    output logic [din_mode_pkg::CNT_W-1:0]     countThird,
    output logic [din_mode_pkg::CNT_W-1:0]     periodSecond,
    output logic [din_mode_pkg::CNT_W-1:0]     periodThird,
    output logic [1:0]                         captureTrigger,
    output logic [1:0]                         logTrigger,
    output logic [1:0]                         intervalGate,
    output logic [1:0]                         linearizeSecond,
    output logic [1:0]                         linearizeThird,
    output logic                               overrideFourth
);
    import din_mode_pkg::*;
    initial if (TICK_CYCLES < 2 || DEBOUNCE_CYCLES < 1) $error("bad timing parameters");

    localparam int unsigned TW = $clog2(TICK_CYCLES);

    logic [7:0]       cfg [2];
    logic [1:0]       pin;
    logic [1:0]       rise;
    logic [1:0]       useDb;
    chan_act_e        act [2];
    logic [2:0]       opt [2];
    logic [1:0]       claimed;
    logic [TW-1:0]    tick_ff, nxt_tick;
    logic             tickPulse;
    logic [CNT_W-1:0] cnt_ff [2];
    logic [CNT_W-1:0] nxt_cnt [2];
    logic [1:0]       cap_ff, nxt_cap, log_ff, nxt_log, gate_ff, nxt_gate, st_ff, nxt_st;
    logic [1:0]       linB_ff, nxt_linB, linC_ff, nxt_linC;
    logic             ovr_ff, nxt_ovr;
    logic [CNT_W-1:0] perW [2];

    assign cfg[0] = channel_b_input_config;
    assign cfg[1] = channel_c_input_config;
    assign pin    = {input_pin_third, input_pin_second};
    // Pins taken by analogue output or by a neighbour lose their own mode
    assign claimed = {analogClaimsThird, analogClaimsSecond | firstUsesSecondPin}; // RQ17 RQ18 RQ20

    // Per-channel decode of function and option
    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            always_comb begin
                opt[ch] = cfgOpt(cfg[ch]);
                useDb[ch] = 1'b0;
                if (claimed[ch]) begin
                    act[ch] = ACT_IDLE; // RQ17
                end else if (cfgFunc(cfg[ch]) == FUNC_INPUT) begin
                    act[ch] = ACT_INPUT; // RQ4
                    useDb[ch] = opt[ch][2]; // RQ8
                end else if (cfgFunc(cfg[ch]) == FUNC_COUNT) begin
                    act[ch] = ACT_COUNT; // RQ4
                    useDb[ch] = opt[ch][2]; // RQ9 RQ12
                end else if (cfgFunc(cfg[ch]) == FUNC_FREQ) begin
                    act[ch] = ACT_FREQ; // RQ4
                end else begin
                    act[ch] = ACT_IDLE; // RQ16
                end
            end

            edge_debounce #(
                .HOLD_CYC   (DEBOUNCE_CYCLES)
            ) u_deb (
                .sys_clk     (sys_clk),
                .reset       (reset),
                .pinIn       (pin[ch]),
                .useDebounce (useDb[ch]),
                .risePulse   (rise[ch])
            );

            freq_meter #(
                .CNT_W    (CNT_W),
                .RESET_TK (RESET_TICKS),
                .DECAY_TK (DECAY_TICKS)
            ) u_freq (
                .sys_clk   (sys_clk),
                .reset     (reset),
                .enable    (act[ch] == ACT_FREQ),
                .tick      (tickPulse),
                .pulse     (rise[ch]),
                .fastReset (opt[ch] == 3'h1), // RQ15
                .period    (perW[ch])
            );
        end
    endgenerate

    // Timebase divider for frequency measurement
    always_comb begin
        tickPulse = (tick_ff == TW'(TICK_CYCLES - 1));
        nxt_tick  = tickPulse ? '0 : tick_ff + TW'(1);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= nxt_tick;
        end
    end

    // Counters, triggers and power-up restore
    always_comb begin
        nxt_cnt[0] = cnt_ff[0];
        nxt_cnt[1] = cnt_ff[1];
        nxt_cap  = 2'h0;
        nxt_log  = 2'h0;
        nxt_gate = 2'h0;
        nxt_st   = 2'h0;
        for (int ch = 0; ch < 2; ch++) begin
            if (act[ch] == ACT_INPUT) begin
                nxt_st[ch] = pin[ch];
                if (opt[ch][1:0] == 2'h1) begin
                    nxt_cap[ch] = rise[ch]; // RQ5 RQ8
                end
                if (opt[ch][1:0] == 2'h2 || opt[ch][1:0] == 2'h3) begin
                    nxt_log[ch] = rise[ch]; // RQ6 RQ7 RQ8
                end
                if (opt[ch][1:0] == 2'h3) begin
                    nxt_gate[ch] = pin[ch]; // RQ7
                end
            end
        end
        // Second channel: plain up count, reserved options count nothing
        if (act[0] == ACT_COUNT && opt[0][1:0] == 2'h0 && rise[0]) begin
            nxt_cnt[0] = cnt_ff[0] + CNT_W'(1); // RQ9 RQ21
        end
        // Third channel: up, up/down by fourth pin, gated by fourth pin
        if (act[1] == ACT_COUNT && rise[1]) begin
            if (opt[1][1:0] == 2'h0) begin
                nxt_cnt[1] = cnt_ff[1] + CNT_W'(1); // RQ12
            end else if (opt[1][1:0] == 2'h1) begin
                nxt_cnt[1] = input_pin_fourth ? cnt_ff[1] - CNT_W'(1) : cnt_ff[1] + CNT_W'(1); // RQ10 RQ13
            end else if (opt[1][1:0] == 2'h2 && input_pin_fourth) begin
                nxt_cnt[1] = cnt_ff[1] + CNT_W'(1); // RQ11 RQ13
            end
        end
        if (powerUp) begin
            nxt_cnt[0] = channel_b_input_config[POWER_LSB] ? '0 : savedCountSecond; // RQ1
            nxt_cnt[1] = channel_c_input_config[POWER_LSB] ? '0 : savedCountThird; // RQ1
        end
        // Linearize after scale/offset, table one for second channel
        nxt_linB = (channel_b_input_config[POWER_LSB+1] && scaleDone) ? LIN_TABLE_FIRST : 2'h0; // RQ2 RQ3
        nxt_linC = (channel_c_input_config[POWER_LSB+1] && scaleDone) ? LIN_TABLE_FIRST : 2'h0; // RQ3
        nxt_ovr = (act[1] == ACT_COUNT) && (opt[1][1:0] == 2'h1 || opt[1][1:0] == 2'h2); // RQ19
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_ff[0] <= '0;
            cnt_ff[1] <= '0;
            cap_ff    <= 2'h0;
            log_ff    <= 2'h0;
            gate_ff   <= 2'h0;
            st_ff     <= 2'h0;
            linB_ff   <= 2'h0;
            linC_ff   <= 2'h0;
            ovr_ff    <= 1'b0;
        end else begin
            cnt_ff[0] <= nxt_cnt[0];
            cnt_ff[1] <= nxt_cnt[1];
            cap_ff    <= nxt_cap;
            log_ff    <= nxt_log;
            gate_ff   <= nxt_gate;
            st_ff     <= nxt_st;
            linB_ff   <= nxt_linB;
            linC_ff   <= nxt_linC;
            ovr_ff    <= nxt_ovr;
        end
    end

    // Outputs straight from flops
    assign countSecond     = cnt_ff[0];
    assign countThird      = cnt_ff[1];
    assign periodSecond    = perW[0];
    assign periodThird     = perW[1];
    assign captureTrigger  = cap_ff;
    assign logTrigger      = log_ff;
    assign intervalGate    = gate_ff;
    assign inputState      = st_ff;
    assign linearizeSecond = linB_ff;
    assign linearizeThird  = linC_ff;
    assign overrideFourth  = ovr_ff;

    power_clear_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ1
        powerUp && channel_b_input_config[POWER_LSB] |=> countSecond == '0) else $error("count not cleared");
    power_restore_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ1
        powerUp && !channel_c_input_config[POWER_LSB] |=> countThird == $past(savedCountThird))
        else $error("count not restored");
    capture_edge_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ5
        captureTrigger[0] |-> $past(rise[0]) && $past(channel_b_input_config[FUNC_LSB +: 3]) == FUNC_INPUT)
        else $error("capture without edge");
    log_edge_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ6
        logTrigger[1] |-> $past(rise[1])) else $error("log without edge");
    updown_dir_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ10
        !powerUp && act[1] == ACT_COUNT && opt[1] == 3'h1 && rise[1] && input_pin_fourth
        |=> countThird == $past(countThird) - CNT_W'(1)) else $error("down count wrong");
    gated_off_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ11
        !powerUp && act[1] == ACT_COUNT && opt[1] == 3'h2 && !input_pin_fourth
        |=> $stable(countThird)) else $error("gated count moved");
    reserved_hold_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ16
        !powerUp && cfgFunc(channel_b_input_config) > FUNC_FREQ |=> $stable(countSecond) && !captureTrigger[0])
        else $error("reserved function acted");
    override_c_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ19
        !claimed[1] && cfgFunc(channel_c_input_config) == FUNC_COUNT && opt[1] == 3'h5 |=> overrideFourth)
        else $error("fourth pin not overridden");
    // Linearize flags wait for scale and offset
    lin_after_scale_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ3
        !scaleDone |=> linearizeSecond == 2'h0 && linearizeThird == 2'h0) else $error("linearized before scaling");
    lin_table_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ2
        scaleDone && channel_b_input_config[POWER_LSB+1] |=> linearizeSecond == LIN_TABLE_FIRST)
        else $error("second channel table wrong");
    // Claimed pins and reserved options leave results alone
    claimed_idle_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ17
        !powerUp && claimed[1] |=> $stable(countThird) && captureTrigger[1] == 1'b0 && logTrigger[1] == 1'b0)
        else $error("claimed pin still acted");
    second_blocked_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ18
        !powerUp && firstUsesSecondPin |=> $stable(countSecond) && inputState[0] == 1'b0)
        else $error("second channel not overridden");
    b_reserved_opt_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ9
        !powerUp && act[0] == ACT_COUNT && opt[0][1:0] != 2'h0 |=> $stable(countSecond))
        else $error("reserved counter option counted");
    up_count_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ12
        !powerUp && act[1] == ACT_COUNT && opt[1][1:0] == 2'h0 && rise[1]
        |=> countThird == $past(countThird) + CNT_W'(1)) else $error("up count wrong");
    gate_level_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ7
        act[0] == ACT_INPUT && opt[0][1:0] == 2'h3 |=> intervalGate[0] == $past(input_pin_second))
        else $error("interval gate wrong");
endmodule // digital_input_counter_modes
`default_nettype wire

// [din_mode_pkg.sv]
// Overview of operation
// RQ1 - Power-up code picks restore or clear count
// RQ2 - Channel second linearizes with first table
// RQ3 - Linearize only after scale and offset
// RQ4 - Function field: input, counter, frequency, reserved
// RQ5 - Option 1 pulses capture on leading edge
// RQ6 - Option 2 pulses log sample per edge
// RQ7 - Option 3 gates interval logging, logs edges
// RQ8 - Options 5-7 add 5 ms debounce
// RQ9 - Channel second counter: options 0, 4 only
// RQ10 - Third channel option 1 counts up/down
// RQ11 - Third channel option 2 gated up count
// RQ12 - Options 4-6 are debounced counter variants
// RQ13 - Debounce count input only, not direction
// RQ14 - Frequency option 0 decays within 100 s
// RQ15 - Frequency option 1 zeroes after 1 s
// RQ16 - Reserved function ignores option field
// RQ17 - Analogue pin claim overrides input mode
// RQ18 - First channel direction use overrides second
// RQ19 - Third channel direction use overrides fourth
// RQ20 - First channel option 1 counts by second pin
// RQ21 - Reserved option means base function only; the counter's reserved options count nothing
// RQ22 - Debounce holds off transitions for period
package din_mode_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned DEBOUNCE_US    = 5000;
    localparam int unsigned DEBOUNCE_CYC   = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
    localparam int unsigned TICK_US        = 10000;
    localparam int unsigned TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int unsigned FREQ_RESET_MS  = 1000;
    localparam int unsigned FREQ_RESET_TK  = FREQ_RESET_MS * 1000 / TICK_US;
    localparam int unsigned FREQ_DECAY_S   = 100;
    localparam int unsigned FREQ_DECAY_TK  = FREQ_DECAY_S * 1_000_000 / TICK_US;
    localparam int unsigned CNT_W          = 32;
    localparam int unsigned POWER_LSB      = 6;
    localparam int unsigned FUNC_LSB       = 3;
    localparam int unsigned OPT_LSB        = 0;
    localparam logic [7:0]  CFG_RESET      = 8'h00;
    localparam logic [1:0]  PWR_CLEAR_BIT  = 2'h1;
    localparam logic [1:0]  PWR_LIN_BIT    = 2'h2;
    localparam logic [2:0]  FUNC_INPUT     = 3'h0;
    localparam logic [2:0]  FUNC_COUNT     = 3'h1;
    localparam logic [2:0]  FUNC_FREQ      = 3'h2;
    localparam logic [1:0]  LIN_TABLE_FIRST = 2'h1;

    typedef enum logic [3:0] {
        ACT_INPUT = 4'b0001,
        ACT_COUNT = 4'b0010,
        ACT_FREQ  = 4'b0100,
        ACT_IDLE  = 4'b1000
    } chan_act_e;

    // Split one octal-coded mode byte
    function automatic logic [2:0] cfgFunc(input logic [7:0] c);
        return c[FUNC_LSB +: 3];
    endfunction
    function automatic logic [2:0] cfgOpt(input logic [7:0] c);
        return c[OPT_LSB +: 3];
    endfunction
endpackage

// [edge_debounce.sv]
`timescale 1ns/1ps
`default_nettype none
module edge_debounce #(
    parameter int unsigned HOLD_CYC = 125000
) (
    input  wire logic sys_clk,
    input  wire logic reset,
    input  wire logic pinIn,
    input  wire logic useDebounce,
    output logic      risePulse
);
    import din_mode_pkg::*;
    localparam int unsigned CW = $clog2(HOLD_CYC + 1);
    initial if (HOLD_CYC < 1) $error("HOLD_CYC too small");

    logic          prev_ff, nxt_prev;
    logic [CW-1:0] hold_ff, nxt_hold;
    logic          rise;

    // Edge detect with hold-off after an accepted edge
    always_comb begin
        rise     = pinIn & ~prev_ff;
        nxt_prev = pinIn;
        nxt_hold = hold_ff;
        if (hold_ff != '0) begin
            nxt_hold = hold_ff - CW'(1); // RQ22
        end else if (rise && useDebounce) begin
            nxt_hold = CW'(HOLD_CYC); // RQ8 RQ13
        end
        if (useDebounce && hold_ff != '0) begin
            nxt_prev = prev_ff; // RQ22
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_ff <= 1'b0;
            hold_ff <= '0;
        end else begin
            prev_ff <= nxt_prev;
            hold_ff <= nxt_hold;
        end
    end

    assign risePulse = rise && !(useDebounce && hold_ff != '0);

    hold_off_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ22
        useDebounce && risePulse |=> !risePulse [*8]) else $error("edge accepted during hold-off");
endmodule // edge_debounce
`default_nettype wire

// [freq_meter.sv]
`timescale 1ns/1ps
`default_nettype none
module freq_meter #(
    parameter int unsigned CNT_W    = 32,
    parameter int unsigned RESET_TK = 100,
    parameter int unsigned DECAY_TK = 10000
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             enable,
    input  wire logic             tick,
    input  wire logic             pulse,
    input  wire logic             fastReset,
    output logic [CNT_W-1:0]      period
);
    import din_mode_pkg::*;
    initial if (RESET_TK < 1 || DECAY_TK <= RESET_TK) $error("bad freq limits");

    logic [CNT_W-1:0] gap_ff, nxt_gap;
    logic [CNT_W-1:0] per_ff, nxt_per;

    // Period in ticks between edges; a silent gap stretches it, zero means none
    always_comb begin
        nxt_gap = gap_ff;
        nxt_per = per_ff;
        if (!enable) begin
            nxt_gap = '0;
            nxt_per = '0;
        end else if (pulse) begin
            nxt_per = gap_ff + CNT_W'(1);
            nxt_gap = '0;
        end else if (tick) begin
            nxt_gap = gap_ff + CNT_W'(1);
            if (fastReset && gap_ff >= CNT_W'(RESET_TK)) begin
                nxt_per = '0; // RQ15
            end else if (!fastReset && gap_ff >= CNT_W'(DECAY_TK)) begin
                nxt_per = '0; // RQ14
            end else if (gap_ff >= per_ff && per_ff != '0) begin
                nxt_per = gap_ff + CNT_W'(1); // RQ14
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            gap_ff <= '0;
            per_ff <= '0;
        end else begin
            gap_ff <= nxt_gap;
            per_ff <= nxt_per;
        end
    end

    assign period = per_ff;

    fast_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ15
        enable && fastReset && tick && !pulse && gap_ff >= CNT_W'(RESET_TK) |=> per_ff == '0)
        else $error("period not cleared after quiet second");
    decay_zero_a: assert property (@(posedge sys_clk) disable iff (reset) // RQ14
        enable && !fastReset && tick && !pulse && gap_ff >= CNT_W'(DECAY_TK) |=> per_ff == '0)
        else $error("period not cleared after decay limit");
endmodule // freq_meter
`default_nettype wire

// [field_pin_source.sv]
`timescale 1ns/1ps
`default_nettype none
module field_pin_source (
    input  wire logic sys_clk,
    output logic      pinFirst,
    output logic      pinSecond,
    output logic      pinThird,
    output logic      pinFourth
);
    // Isolated inputs idle low between pulses
    initial begin
        pinFirst  = 1'b0;
        pinSecond = 1'b0;
        pinThird  = 1'b0;
        pinFourth = 1'b0;
    end

    // Pulse trains on first three pins, hi cycles high then lo cycles low
    task automatic pulses(input int n, input int hi, input int lo);
        repeat (n) begin
            @(negedge sys_clk);
            pinFirst  = 1'b1;
            pinSecond = 1'b1;
            pinThird  = 1'b1;
            repeat (hi) @(negedge sys_clk);
            pinFirst  = 1'b0;
            pinSecond = 1'b0;
            pinThird  = 1'b0;
            repeat (lo - 1) @(negedge sys_clk);
        end
    endtask

    // Steady levels on count pins
    task automatic setCount(input logic lvl);
        @(negedge sys_clk);
        pinSecond = lvl;
        pinThird  = lvl;
    endtask

    // Direction or gate level, never bounced
    task automatic setFourth(input logic lvl);
        @(negedge sys_clk);
        pinFourth = lvl;
    endtask
endmodule // field_pin_source
`default_nettype wire

// [test_digital_input_counter_modes.sv]
`timescale 1ns/1ps
`default_nettype none
module test_digital_input_counter_modes;
    import din_mode_pkg::*;
    typedef struct {
        logic [7:0]  cb, cc;
        logic        d;
        logic [2:0]  ovr;
        int          n, hi, lo, capB, capC, logB, logC;
        logic [31:0] cntB, cntC;
        logic        ovr4;
    } row_s;
    logic        sysClk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  cfgB = 8'h00, cfgC = 8'h00;
    logic [31:0] savedB = 32'h64, savedC = 32'h64;
    logic        firstUses = 1'b0, anaB = 1'b0, anaC = 1'b0, powerUp = 1'b0, scaleDone = 1'b1;
    wire logic   pinA, pinB, pinC, pinD;
    logic [1:0]  inputState, captureTrigger, logTrigger, intervalGate, linB, linC;
    logic [31:0] countSecond, countThird, periodSecond, periodThird;
    logic        overrideFourth;
    int          mismatches = 0, checkCount = 0, cycles = 0;
    int          tally[4];
    // Counts cap B, cap C, log B, log C, then powered-up counts
    row_s rows[16] = '{
        '{8'h01, 8'h02, 1'b0, 3'h0, 3, 3, 12, 3, 0, 0, 3, 32'h64, 32'h64, 1'b0},
        '{8'h03, 8'h05, 1'b0, 3'h0, 3, 3, 12, 0, 3, 3, 0, 32'h64, 32'h64, 1'b0},
        '{8'h06, 8'h07, 1'b0, 3'h0, 3, 3, 12, 0, 0, 3, 3, 32'h64, 32'h64, 1'b0},
        '{8'h08, 8'h09, 1'b0, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h67, 32'h67, 1'b1},
        '{8'h0C, 8'h09, 1'b1, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h67, 32'h61, 1'b1},
        '{8'h09, 8'h0A, 1'b0, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h64, 1'b1},
        '{8'h04, 8'h0A, 1'b1, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h67, 1'b1},
        '{8'h18, 8'h0E, 1'b1, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h67, 1'b1},
        '{8'h0D, 8'h0D, 1'b1, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h61, 1'b1},
        '{8'h39, 8'h0B, 1'b0, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h64, 1'b0},
        '{8'h0E, 8'h0C, 1'b0, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h67, 1'b0},
        '{8'h08, 8'h08, 1'b0, 3'h6, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h67, 1'b0},
        '{8'h08, 8'h08, 1'b0, 3'h1, 3, 3, 12, 0, 0, 0, 0, 32'h67, 32'h64, 1'b0},
        '{8'h3F, 8'h3F, 1'b0, 3'h0, 3, 3, 12, 0, 0, 0, 0, 32'h64, 32'h64, 1'b0},
        '{8'h05, 8'h0D, 1'b1, 3'h0, 2, 1, 2, 1, 0, 0, 0, 32'h64, 32'h63, 1'b1},
        '{8'h01, 8'h09, 1'b1, 3'h0, 2, 1, 2, 2, 0, 0, 0, 32'h64, 32'h62, 1'b1}
    };

    always #20 sysClk = ~sysClk;

    // Field side model
    field_pin_source u_field (.sys_clk(sysClk), .pinFirst(pinA), .pinSecond(pinB), .pinThird(pinC),
                              .pinFourth(pinD));

    digital_input_counter_modes #(.DEBOUNCE_CYCLES(8), .TICK_CYCLES(4), .RESET_TICKS(3), .DECAY_TICKS(20)) u_dut (
        .sys_clk(sysClk), .reset(reset), .input_pin_first(pinA), .input_pin_second(pinB),
        .input_pin_third(pinC), .input_pin_fourth(pinD), .channel_b_input_config(cfgB),
        .channel_c_input_config(cfgC), .firstUsesSecondPin(firstUses), .analogClaimsSecond(anaB),
        .analogClaimsThird(anaC), .powerUp(powerUp), .savedCountSecond(savedB), .savedCountThird(savedC),
        .scaleDone(scaleDone), .inputState(inputState), .countSecond(countSecond), .countThird(countThird),
        .periodSecond(periodSecond), .periodThird(periodThird), .captureTrigger(captureTrigger),
        .logTrigger(logTrigger), .intervalGate(intervalGate), .linearizeSecond(linB),
        .linearizeThird(linC), .overrideFourth(overrideFourth));

    // Trigger pulse tallies and hang guard
    always @(posedge sysClk) begin
        cycles++;
        for (int k = 0; k < 2; k++) begin
            if (captureTrigger[k] === 1'b1) tally[k]++;
            if (logTrigger[k] === 1'b1) tally[k+2]++;
        end
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end

    task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checkCount > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Load both configs and strobe power-up for one cycle
    task automatic pwr(input logic [7:0] b, input logic [7:0] c);
        @(negedge sysClk);
        cfgB = b;
        cfgC = c;
        powerUp = 1'b1;
        @(negedge sysClk);
        powerUp = 1'b0;
        repeat (3) @(negedge sysClk);
    endtask

    task automatic runRow(input row_s r);
        u_field.setFourth(r.d);
        firstUses = r.ovr[2];
        anaB = r.ovr[1];
        anaC = r.ovr[0];
        pwr(r.cb, r.cc);
        tally = '{0, 0, 0, 0};
        u_field.pulses(r.n, r.hi, r.lo);
        repeat (4) @(negedge sysClk);
        cmpWord(32'(tally[0]), 32'(r.capB));
        cmpWord(32'(tally[1]), 32'(r.capC));
        cmpWord(32'(tally[2]), 32'(r.logB));
        cmpWord(32'(tally[3]), 32'(r.logC));
        cmpWord(countSecond, r.cntB);
        cmpWord(countThird, r.cntC);
        cmpWord({31'h0, overrideFourth}, {31'h0, r.ovr4});
    endtask

    initial begin
        repeat (16) @(negedge sysClk);
        reset = 1'b0;
        @(negedge sysClk);
        cmpWord(countSecond, 32'h0);
        cmpWord({26'h0, captureTrigger, logTrigger, linB}, 32'h0);
        foreach (rows[i]) runRow(rows[i]);
        u_field.setFourth(1'b0);
        firstUses = 1'b0;
        anaB = 1'b0;
        anaC = 1'b0;
        // Power-up clear and linearize choices
        pwr(8'h48, 8'hC8);
        cmpWord(countSecond, 32'h0);
        cmpWord(countThird, 32'h0);
        cmpWord({30'h0, linB, linC}, {28'h0, 2'h0, LIN_TABLE_FIRST});
        savedB = 32'hA5;
        savedC = 32'h5A;
        pwr(8'h88, 8'h00);
        cmpWord(countSecond, 32'hA5);
        cmpWord(countThird, 32'h5A);
        cmpWord({30'h0, linB}, {30'h0, LIN_TABLE_FIRST});
        scaleDone = 1'b0;
        repeat (3) @(negedge sysClk);
        cmpWord({30'h0, linB}, 32'h0);
        // Input level and gated interval logging
        pwr(8'h03, 8'h00);
        u_field.setCount(1'b1);
        repeat (3) @(negedge sysClk);
        cmpWord({30'h0, inputState}, 32'h3);
        cmpWord({31'h0, intervalGate[0]}, 32'h1);
        u_field.setCount(1'b0);
        repeat (3) @(negedge sysClk);
        cmpWord({28'h0, inputState, intervalGate}, 32'h0);
        // Frequency: fast zero on one channel, slow decay on the other
        pwr(8'h11, 8'h10);
        u_field.pulses(4, 2, 6);
        cmpWord({30'h0, |periodSecond, |periodThird}, 32'h3);
        repeat (30) @(negedge sysClk);
        cmpWord(periodSecond, 32'h0);
        cmpWord({31'h0, |periodThird}, 32'h1);
        repeat (80) @(negedge sysClk);
        cmpWord(periodThird, 32'h0);
        // Mid-run reset clears every result
        reset = 1'b1;
        repeat (2) @(negedge sysClk);
        reset = 1'b0;
        @(negedge sysClk);
        cmpWord(countSecond | countThird | periodSecond | periodThird, 32'h0);
        cmpWord({19'h0, inputState, captureTrigger, logTrigger, intervalGate, linB, linC, overrideFourth}, 32'h0);
        finish_test();
    end
endmodule // test_digital_input_counter_modes
`default_nettype wire
